// [src/otppv_top.sv]
// program and verify port of the on-chip one-time-programmable code memory
// Operation
// - clocked logic performs the array write
// - any lock blocks code and key writes
// - verify mode shows addressed byte on port 0
// - verify output is code XNOR key byte
// - key table never readable
// - signature bytes at 030 and 031
// - lock one: table loads blocked, pin latched
// - lock two also disables verify
// - lock three blocks external code and RAM
// - erase restores ones, clears key and locks
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`include "otppv_consts.svh"
module otppv_top
   import otppv_pkg::*;
#(
   parameter int         CODE_AW    = `OTPPV_CODE_AW,
   parameter int         KEY_AW     = `OTPPV_KEY_AW,
   parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] PART_CODE  = 8'h5A  // arbitrary value
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_reset_pin,
   input  wire logic        i_program_fetch_strobe_n,
   input  wire logic        i_latch_and_write_pulse_pin,
   input  wire logic        i_external_access_supply_pin,
   input  wire logic        i_vpp_present,
   input  wire logic [7:0]  i_port0,
   input  wire logic [7:0]  i_port1,
   input  wire logic [7:0]  i_port2,
   input  wire logic [7:0]  i_port3,
   output      logic [7:0]  o_port0_out,
   output      logic [7:0]  o_port0_oe,
   output      logic        o_external_access_pin,
   output      logic        o_table_load_block,
   output      logic        o_ext_exec_block,
   output      logic        o_data_ram_block,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output      logic [31:0] o_wb_dat,
   output      logic        o_wb_ack
);

   otppv_seq_if seq ();
   otppv_mem_if mem ();

   otppv_mode_type mode;
   logic [13:0]    pin_addr;
   logic           sel_ok;
   logic           prog_ok;
   logic           read_ok;
   logic           any_lock;
   logic [7:0]     verify_byte;
   logic [2:0]     lock_q;
   logic [2:0]     lock_set;
   logic           key_used_q;
   logic           pen_q;
   logic           erase_q;
   logic           rst_seen_q;
   logic           ea_latch_q;
   logic [7:0]     p0_oe_q;
   logic [7:0]     p0_out_q;
   logic           ea_out_q;
   logic           tl_blk_q;
   logic           ex_blk_q;
   logic           ram_blk_q;
   logic           ack_q;
   logic [31:0]    dat_q;
   logic           wb_req;
   logic           wb_wr;

   // -------------------------------------------------------------------------
   // mode selection from the pins
   // -------------------------------------------------------------------------
   assign sel_ok   = i_reset_pin && !i_program_fetch_strobe_n;
   assign mode     = sel_ok ? otppv_decode({i_port2[7:6], i_port3[7:6]}) : MODE_NONE;
   assign pin_addr = {i_port2[5:0], i_port1};
   assign prog_ok  = i_vpp_present && pen_q && (mode inside {MODE_CODE, MODE_KEY, MODE_LOCK1,
                                                             MODE_LOCK2, MODE_LOCK3});
   assign read_ok  = i_latch_and_write_pulse_pin && i_external_access_supply_pin;
   assign any_lock = |lock_q;

   assign seq.arm = prog_ok;

   otppv_pulse_counter u_pulse
   (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_pulse_pin (i_latch_and_write_pulse_pin),
      .seq         (seq)
   );

   // -------------------------------------------------------------------------
   // array writes
   // -------------------------------------------------------------------------
   // the pins must stay put past the last pulse rise until seq.done has written; they are used live
   assign mem.addr    = pin_addr;
   assign mem.wdata   = i_port0;
   assign mem.erase   = erase_q;
   assign mem.code_we = seq.done && mode == MODE_CODE && !any_lock;
   assign mem.key_we  = seq.done && mode == MODE_KEY && !any_lock
                        && pin_addr[13:KEY_AW] == '0;

   otppv_array #(
      .CODE_AW (CODE_AW),
      .KEY_AW  (KEY_AW)
   ) u_array
   (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .mem       (mem)
   );

   // -------------------------------------------------------------------------
   // lock bits and key flag
   // -------------------------------------------------------------------------
   // lock writes stay open after the first lock; a set beats a same-cycle erase
   always_comb
   begin
      lock_set    = 3'h0;
      lock_set[0] = seq.done && mode == MODE_LOCK1;
      lock_set[1] = seq.done && mode == MODE_LOCK2;
      lock_set[2] = seq.done && mode == MODE_LOCK3;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         lock_q <= 3'h0;
      end
      else
      begin
         lock_q <= (erase_q ? 3'h0 : lock_q) | lock_set;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         key_used_q <= 1'b0;
      end
      else
      begin
         key_used_q <= (key_used_q && !erase_q) || mem.key_we;
      end
   end

   // -------------------------------------------------------------------------
   // verify and signature read-out
   // -------------------------------------------------------------------------
   // an erased key byte is all ones, so the XNOR passes code through unchanged
   assign verify_byte = ~(mem.code_rd ^ mem.key_rd);

   // only zeros are driven; ones come from the external pull-ups
   always_ff @(posedge i_sys_clk)
   begin
      p0_out_q <= 8'h00;
      if (!i_rst_n)
      begin
         p0_oe_q <= 8'h00;
      end
      else if (read_ok && mode == MODE_VERIFY && !lock_q[1])
      begin
         p0_oe_q <= ~verify_byte;
      end
      else if (read_ok && mode == MODE_SIG && pin_addr == `OTPPV_SIG_ADR0)
      begin
         p0_oe_q <= ~MAKER_CODE;
      end
      else if (read_ok && mode == MODE_SIG && pin_addr == `OTPPV_SIG_ADR1)
      begin
         p0_oe_q <= ~PART_CODE;
      end
      else
      begin
         p0_oe_q <= 8'h00;
      end
   end

   // -------------------------------------------------------------------------
   // protection outputs to the core
   // -------------------------------------------------------------------------
   // undefined lock patterns are handled bit by bit, each bit adds its own restriction
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         rst_seen_q <= 1'b0;
         ea_latch_q <= 1'b0;
      end
      else
      begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q)
         begin
            ea_latch_q <= i_external_access_supply_pin;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         ea_out_q  <= 1'b0;
         tl_blk_q  <= 1'b0;
         ex_blk_q  <= 1'b0;
         ram_blk_q <= 1'b0;
      end
      else
      begin
         ea_out_q  <= any_lock ? ea_latch_q : i_external_access_supply_pin;
         tl_blk_q  <= any_lock;
         ex_blk_q  <= lock_q[2];
         ram_blk_q <= lock_q[2];
      end
   end

   assign o_port0_out           = p0_out_q;
   assign o_port0_oe            = p0_oe_q;
   assign o_external_access_pin = ea_out_q;
   assign o_table_load_block    = tl_blk_q;
   assign o_ext_exec_block      = ex_blk_q;
   assign o_data_ram_block      = ram_blk_q;

   // -------------------------------------------------------------------------
   // wishbone slave
   // -------------------------------------------------------------------------
   // one wait state; writes land on the edge where the master sees ack
   assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;
   assign wb_wr  = ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]
                   && i_wb_adr == `OTPPV_CTRL_OFS;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= wb_req;
         if (wb_req)
         begin
            dat_q <= 32'h0000_0000;
            if (i_wb_adr == `OTPPV_CTRL_OFS)
            begin
               dat_q[`OTPPV_CTRL_PEN_BIT] <= pen_q;
            end
            else if (i_wb_adr == `OTPPV_STAT_OFS)
            begin
               dat_q[`OTPPV_STAT_LOCK_LSB +: 3] <= lock_q;
               dat_q[`OTPPV_STAT_KEY_BIT]       <= key_used_q;
               dat_q[`OTPPV_STAT_CNT_LSB +: 5]  <= seq.count;
               dat_q[`OTPPV_STAT_ARM_BIT]       <= prog_ok;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         pen_q   <= 1'(`OTPPV_CTRL_RST >> `OTPPV_CTRL_PEN_BIT);
         erase_q <= 1'b0;
      end
      else
      begin
         erase_q <= wb_wr && i_wb_dat[`OTPPV_CTRL_ERASE_BIT];
         if (wb_wr)
         begin
            pen_q <= i_wb_dat[`OTPPV_CTRL_PEN_BIT];
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_verify_open;
      read_ok && mode == MODE_VERIFY && !lock_q[1];
   endsequence

   sequence s_erase_cmd;
      wb_wr && i_wb_dat[`OTPPV_CTRL_ERASE_BIT] ##1 lock_set == 3'h0 && !mem.key_we;
   endsequence

   AST_LOCK_BLOCKS_WRITE: assert property (any_lock |-> !mem.code_we && !mem.key_we)
      else $error("array write while locked");

   AST_LOCK_STILL_SETS: assert property (lock_set[1] |=> lock_q[1])
      else $error("lock bit not taken");

   AST_VERIFY_XNOR: assert property (s_verify_open |=> p0_oe_q == ~$past(verify_byte))
      else $error("verify byte wrong");

   AST_VERIFY_LOCKED: assert property (read_ok && lock_q[1] && mode == MODE_VERIFY |=> ~|p0_oe_q)
      else $error("verify not released under lock two");

   AST_NO_OTHER_DRIVE: assert property (!(mode inside {MODE_VERIFY, MODE_SIG}) |=> p0_oe_q == 8'h00)
      else $error("port 0 driven outside read modes");

   AST_SIG_MAKER: assert property (read_ok && mode == MODE_SIG && pin_addr == `OTPPV_SIG_ADR0
                                   |=> p0_oe_q == ~MAKER_CODE)
      else $error("maker code wrong");

   AST_LOCK1_EFFECT: assert property (lock_q[0] |=> tl_blk_q && ea_out_q == ea_latch_q)
      else $error("lock one restrictions missing");

   AST_LOCK3_EFFECT: assert property (lock_q[2] |=> ex_blk_q && ram_blk_q)
      else $error("lock three restrictions missing");

   AST_ERASE_CLEARS: assert property (s_erase_cmd |=> lock_q == 3'h0 && !key_used_q)
      else $error("erase left protection set");

   AST_WB_ACK_PULSE: assert property (ack_q |=> !ack_q)
      else $error("ack held longer than one cycle");

endmodule : otppv_top

// [src/otppv_consts.svh]
// constants of the one-time-programmable program and verify port
`ifndef OTPPV_CONSTS_SVH
`define OTPPV_CONSTS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define OTPPV_CTRL_OFS        8'h00
`define OTPPV_STAT_OFS        8'h04
`define OTPPV_CTRL_ERASE_BIT  0
`define OTPPV_CTRL_PEN_BIT    1
`define OTPPV_CTRL_RST        2'h2
`define OTPPV_STAT_LOCK_LSB   0
`define OTPPV_STAT_KEY_BIT    3
`define OTPPV_STAT_CNT_LSB    4
`define OTPPV_STAT_ARM_BIT    9

// ----------------------------------------------------------------------------
// array geometry and fixed locations
// ----------------------------------------------------------------------------
`define OTPPV_CODE_AW         14
`define OTPPV_KEY_AW          6
`define OTPPV_SIG_ADR0        14'h0030
`define OTPPV_SIG_ADR1        14'h0031
`define OTPPV_ERASED_BYTE     8'hFF

// ----------------------------------------------------------------------------
// pulse timing at a 20 MHz system clock
// ----------------------------------------------------------------------------
`define OTPPV_PULSES          5'h19
`define OTPPV_CLK_MHZ         20
`define OTPPV_PULSE_MIN_US    90
`define OTPPV_PULSE_MAX_US    110
`define OTPPV_GAP_MIN_US      10
`define OTPPV_PULSE_MIN_CYC   ((`OTPPV_PULSE_MIN_US * `OTPPV_CLK_MHZ + 0) / 1)
`define OTPPV_PULSE_MAX_CYC   ((`OTPPV_PULSE_MAX_US * `OTPPV_CLK_MHZ) / 1)
`define OTPPV_GAP_MIN_CYC     ((`OTPPV_GAP_MIN_US * `OTPPV_CLK_MHZ + 0) / 1)

`endif

// [src/otppv_pkg.sv]
// types and mode decoding of the program and verify port
package otppv_pkg;

   // -------------------------------------------------------------------------
   // operating modes selected by the mode pins
   // -------------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      MODE_NONE   = 3'b000,
      MODE_SIG    = 3'b001,
      MODE_VERIFY = 3'b010,
      MODE_CODE   = 3'b011,
      MODE_KEY    = 3'b100,
      MODE_LOCK1  = 3'b101,
      MODE_LOCK2  = 3'b110,
      MODE_LOCK3  = 3'b111
   } otppv_mode_type;

   typedef enum logic [1:0]
   {
      PS_IDLE = 2'b00,
      PS_HIGH = 2'b01,
      PS_LOW  = 2'b10,
      PS_DONE = 2'b11
   } otppv_pstate_type;

   // port2 bit7, port2 bit6, port3 bit7, port3 bit6
   function automatic otppv_mode_type otppv_decode(input logic [3:0] sel);
      otppv_mode_type m;
      case (sel)
         4'h0:    m = MODE_SIG;
         4'h3:    m = MODE_VERIFY;
         4'hB:    m = MODE_CODE;
         4'hA:    m = MODE_KEY;
         4'hF:    m = MODE_LOCK1;
         4'hC:    m = MODE_LOCK2;
         4'h5:    m = MODE_LOCK3;
         default: m = MODE_NONE;
      endcase
      return m;
   endfunction : otppv_decode

endpackage : otppv_pkg

// [src/otppv_if.sv]
// carriers between the port controller, its pulse counter and its array

// ----------------------------------------------------------------------------
// pulse sequence
// ----------------------------------------------------------------------------
interface otppv_seq_if;
   logic       arm;
   logic       done;
   logic [4:0] count;
   modport cnt (input arm, output done, output count);
   modport ctl (output arm, input done, input count);
endinterface : otppv_seq_if

// ----------------------------------------------------------------------------
// code array and key table
// ----------------------------------------------------------------------------
interface otppv_mem_if;
   logic [13:0] addr;
   logic [7:0]  wdata;
   logic        code_we;
   logic        key_we;
   logic        erase;
   logic [7:0]  code_rd;
   logic [7:0]  key_rd;
   modport ctl (output addr, output wdata, output code_we, output key_we, output erase,
                input code_rd, input key_rd);
   modport mem (input addr, input wdata, input code_we, input key_we, input erase,
                output code_rd, output key_rd);
endinterface : otppv_mem_if

// [src/otppv_pulse_counter.sv]
// counter of qualified programming pulses on the write pulse pin
`include "otppv_consts.svh"
module otppv_pulse_counter
   import otppv_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pulse_pin,
   otppv_seq_if.cnt  seq
);

   localparam logic [11:0] MIN_CYC = 12'(`OTPPV_PULSE_MIN_CYC);
   localparam logic [11:0] MAX_CYC = 12'(`OTPPV_PULSE_MAX_CYC);
   localparam logic [11:0] GAP_CYC = 12'(`OTPPV_GAP_MIN_CYC);

   otppv_pstate_type st_q;
   logic [11:0]      tim_q;
   logic [4:0]       cnt_q;
   logic             done_q;

   assign seq.done  = done_q;
   assign seq.count = cnt_q;

   // -------------------------------------------------------------------------
   // pulse qualification
   // -------------------------------------------------------------------------
   // a short or overlong pulse, or a short gap, restarts the whole sequence
   always_ff @(posedge i_sys_clk)
   begin
      done_q <= 1'b0;
      if (!i_rst_n || !seq.arm)
      begin
         st_q  <= PS_IDLE;
         tim_q <= 12'h000;
         cnt_q <= 5'h00;
      end
      else
      begin
         if (tim_q != 12'hFFF)
         begin
            tim_q <= tim_q + 12'h001;
         end
         case (st_q)
            PS_IDLE:
            begin
               if (i_pulse_pin)
               begin
                  st_q  <= PS_HIGH;
                  tim_q <= GAP_CYC;
               end
            end
            PS_HIGH:
            begin
               if (!i_pulse_pin)
               begin
                  st_q  <= PS_LOW;
                  tim_q <= 12'h001;
                  if (tim_q < GAP_CYC)
                  begin
                     cnt_q <= 5'h00;
                  end
               end
            end
            PS_LOW:
            begin
               if (i_pulse_pin)
               begin
                  st_q  <= PS_HIGH;
                  tim_q <= 12'h001;
                  if (tim_q >= MIN_CYC && tim_q <= MAX_CYC)
                  begin
                     cnt_q <= cnt_q + 5'h01;
                     if (cnt_q + 5'h01 == `OTPPV_PULSES)
                     begin
                        done_q <= 1'b1;
                        st_q   <= PS_DONE;
                     end
                  end
                  else
                  begin
                     cnt_q <= 5'h00;
                  end
               end
            end
            PS_DONE:
            begin
               st_q <= PS_DONE;
            end
            default:
            begin
               st_q <= PS_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   AST_DONE_AT_COUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      done_q |-> cnt_q == `OTPPV_PULSES && st_q == PS_DONE)
      else $error("write strobe without the full pulse count");

   AST_DONE_ONCE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      done_q |=> !done_q [*2])
      else $error("write strobe repeated within one sequence");

endmodule : otppv_pulse_counter

// [src/otppv_array.sv]
// flip-flop model of the code array and the key table
`include "otppv_consts.svh"
module otppv_array
#(
   parameter int CODE_AW = `OTPPV_CODE_AW,
   parameter int KEY_AW  = `OTPPV_KEY_AW
)
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   otppv_mem_if.mem  mem
);

   logic [7:0] code_q [2**CODE_AW];
   logic [7:0] key_q  [2**KEY_AW];

   assign mem.code_rd = code_q[mem.addr[CODE_AW-1:0]];
   assign mem.key_rd  = key_q[mem.addr[KEY_AW-1:0]];

   // -------------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------------
   // programming can only clear bits, as the cell itself would
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n || mem.erase)
      begin
         for (int i = 0; i < 2**CODE_AW; i++)
         begin
            code_q[i] <= `OTPPV_ERASED_BYTE;
         end
      end
      else if (mem.code_we)
      begin
         code_q[mem.addr[CODE_AW-1:0]] <= code_q[mem.addr[CODE_AW-1:0]] & mem.wdata;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n || mem.erase)
      begin
         for (int i = 0; i < 2**KEY_AW; i++)
         begin
            key_q[i] <= `OTPPV_ERASED_BYTE;
         end
      end
      else if (mem.key_we)
      begin
         key_q[mem.addr[KEY_AW-1:0]] <= key_q[mem.addr[KEY_AW-1:0]] & mem.wdata;
      end
   end

endmodule : otppv_array

// [dv/otppv_prog_model.sv]
// programmer model that pulses the write pulse pin through one programming operation
module otppv_prog_model
#(
   parameter int LOW_CYC = 1810,
   parameter int GAP_CYC = 210
)
(
   input  wire logic i_sys_clk,
   input  wire logic i_go,
   output      logic o_pulse_pin,
   output      logic o_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      o_pulse_pin = 1'b1;
      o_busy      = 1'b0;
      forever
      begin
         @(posedge i_sys_clk);
         if (i_go === 1'b1)
         begin
            o_busy <= 1'b1;
            // widths near the minimum keep the run short
            repeat (25)
            begin
               repeat (GAP_CYC) @(posedge i_sys_clk);
               o_pulse_pin <= 1'b0;
               repeat (LOW_CYC) @(posedge i_sys_clk);
               o_pulse_pin <= 1'b1;
            end
            repeat (GAP_CYC) @(posedge i_sys_clk); // pins stay put past the last rise
            o_busy <= 1'b0;
         end
      end
   end
endmodule : otppv_prog_model

// [dv/otppv_top_tb.sv]
// self-checking bench of the program and verify port
module otppv_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, vpp, ea, go, pchk, pin, busy, cyc, stb, we, ack, rpin, program_fetch_strobe_n_n;
   logic [7:0]  p0, p1, p2, p3, adr, oe, pout;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, exp_q[$];
   logic        tlb, exb, ramb, eao;
   logic [19:0] obs;
   string       nm_q[$];
   int          num_errors = 0, n_compared = 0, cyc_cnt = 0, seed = 35654;
   logic [7:0]  d;
   logic [13:0] a;
   // port 0 read through pull-ups: a line reads 1 unless pulled low; the drive value must stay 0
   assign obs = {pout, tlb, exb, ramb, eao, ~oe};
   otppv_top dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reset_pin(rpin), .i_program_fetch_strobe_n(program_fetch_strobe_n_n),
      .i_latch_and_write_pulse_pin(pin), .i_external_access_supply_pin(ea), .i_vpp_present(vpp),
      .i_port0(p0), .i_port1(p1), .i_port2(p2), .i_port3(p3), .o_port0_out(pout), .o_port0_oe(oe),
      .o_external_access_pin(eao), .o_table_load_block(tlb), .o_ext_exec_block(exb), .o_data_ram_block(ramb),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack));
   otppv_prog_model prog_u (.i_sys_clk(clk), .i_go(go), .o_pulse_pin(pin), .o_busy(busy));
   // ------------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------------
   task automatic wrap_up();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= ad;
      wdat <= dt;
      sel  <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task automatic rd(input string n, input logic [7:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      nm_q.push_back(n);
      wb(1'b0, ad, 32'h0);
   endtask : rd
   task automatic setp(input logic [3:0] m, input logic [13:0] ad, input logic e);
      @(posedge clk);
      p2 <= {m[3:2], ad[13:8]};
      p1 <= ad[7:0];
      p3 <= {m[1:0], 6'h0};
      ea <= e;
      repeat (3) @(posedge clk);
   endtask : setp
   task automatic look(input string n, input logic [11:0] e);
      exp_q.push_back({20'h0, e});
      nm_q.push_back(n);
      @(posedge clk);
      pchk <= 1'b1;
      @(posedge clk);
      pchk <= 1'b0;
   endtask : look
   task automatic prog(input logic [3:0] m, input logic [13:0] ad);
      vpp <= 1'b1;
      setp(m, ad, 1'b1);
      go <= 1'b1;
      do @(posedge clk); while (busy !== 1'b1);
      go <= 1'b0;
      do @(posedge clk); while (busy !== 1'b0);
      vpp <= 1'b0;
      setp(4'h1, ad, 1'b1);
   endtask : prog
   // ------------------------------------------------------------------------
   // clock, timeout and result watcher
   // ------------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc_cnt++;
      // two programming runs of about 50700 cycles each set this ceiling
      if (cyc_cnt == 105000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   always @(posedge clk)
   begin
      logic [31:0] got, e;
      string n;
      if ((ack === 1'b1 && we === 1'b0) || pchk === 1'b1)
      begin
         got = (pchk === 1'b1) ? {12'h0, obs} : rdat;
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
         n = (nm_q.size() > 0) ? nm_q.pop_front() : "unexpected";
         n_compared++;
         if (got !== e)
         begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, got);
         end
      end
   end
   // ------------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------------
   initial
   begin
      rst_n  = 1'b0;
      rpin   = 1'b1;
      program_fetch_strobe_n_n = 1'b0;
      vpp    = 1'b0;
      ea     = 1'b1;
      go     = 1'b0;
      pchk   = 1'b0;
      cyc    = 1'b0;
      stb    = 1'b0;
      we     = 1'b0;
      p0     = 8'h00;
      p1     = 8'h00;
      p2     = 8'h00;
      p3     = 8'h00;
      adr    = 8'h00;
      sel    = 4'h0;
      wdat   = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      d = 8'($random(seed));
      a = 14'($random(seed));
      rd("ctrl reset", 8'h00, 32'h2);
      rd("unmapped read", 8'h08, 32'h0);
      setp(4'h1, a, 1'b0);
      look("live access pin", 12'h0FF);
      setp(4'h3, a, 1'b1);
      look("blank byte", 12'h1FF);
      p0 <= d;
      prog(4'hB, a);
      setp(4'h3, a, 1'b1);
      look("verify byte", {4'h1, d});
      program_fetch_strobe_n_n <= 1'b1;
      look("fetch strobe high", 12'h1FF);
      program_fetch_strobe_n_n <= 1'b0;
      rpin   <= 1'b0;
      look("reset pin low", 12'h1FF);
      rpin   <= 1'b1;
      setp(4'h0, 14'h0030, 1'b1);
      look("maker code", 12'h1A5);
      setp(4'h0, 14'h0031, 1'b1);
      look("part code", 12'h15A);
      setp(4'h0, 14'h0032, 1'b1);
      look("no key path", 12'h1FF);
      prog(4'hF, a);
      rd("status lock one", 8'h04, 32'h1);
      setp(4'h1, a, 1'b0);
      look("lock one pins", 12'h9FF);
      setp(4'h3, a, 1'b1);
      look("verify lock one", {4'h9, d});
      wb(1'b1, 8'h08, 32'h3);
      wb(1'b1, 8'h00, 32'h3);
      rd("ctrl after erase", 8'h00, 32'h2);
      rd("status after erase", 8'h04, 32'h0);
      setp(4'h3, a, 1'b1);
      look("erased byte", 12'h1FF);
      repeat (2) @(posedge clk);
      wrap_up();
   end
endmodule : otppv_top_tb
